// ### hdl/ocm_pkg.sv
// Constants and carrier types for the overcurrent status and monitor gain register bank
package ocm_pkg;

	// ---------------------------------------------------------------
	// Register offsets on the plain register port
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_OC_STATUS  = 8'h13;
	localparam logic [7:0] ADDR_RX_GAIN    = 8'h14;
	localparam logic [7:0] ADDR_TX_GAIN    = 8'h15;
	localparam logic [7:0] ADDR_CTRL       = 8'h16;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h17;
	localparam logic [7:0] ADDR_IRQ_MASK   = 8'h18;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int OC_STATUS_BIT  = 0;
	localparam int CTRL_CURRENT_LIMIT_SELECT_BIT  = 0;
	localparam int IRQ_OC_SET_BIT = 0;
	localparam int IRQ_OC_CLR_BIT = 1;
	localparam int IRQ_SAT_BIT    = 2;
	localparam int IRQ_W          = 3;

	// ---------------------------------------------------------------
	// Values after reset
	// ---------------------------------------------------------------
	localparam logic [7:0]       RX_GAIN_RST  = 8'h00;
	localparam logic [7:0]       TX_GAIN_RST  = 8'h00;
	localparam logic [7:0]       CTRL_RST     = 8'h00;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

	// ---------------------------------------------------------------
	// Gain scaling and thresholds
	// ---------------------------------------------------------------
	localparam logic [7:0] GAIN_UNITY      = 8'h40;
	localparam int         GAIN_SHIFT      = 6;
	localparam int         OC_THR_ILIM0_MA = 160;
	localparam int         OC_THR_ILIM1_MA = 60;
	localparam int         SAMPLE_W        = 16;
	localparam int         MIX_W           = 20;
	localparam logic signed [MIX_W-1:0] MIX_MAX = 20'sh07FFF;
	localparam logic signed [MIX_W-1:0] MIX_MIN = 20'shF8000;

	// ---------------------------------------------------------------
	// Carrier types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ocm_req_t;

	typedef struct packed {
		logic                       valid;
		logic signed [SAMPLE_W-1:0] rx;
		logic signed [SAMPLE_W-1:0] tx;
	} ocm_audio_t;

endpackage

// ### hdl/ocm_gain_scale.sv
// Linear gain stage: sample times code over a power of two, zero code mutes
`timescale 1ns/1ps
module ocm_gain_scale #(
	parameter int SAMPLE_W = ocm_pkg::SAMPLE_W,
	parameter int CODE_W   = 8,
	parameter int SHIFT    = ocm_pkg::GAIN_SHIFT
) (
	input  wire logic                                 clk,       // System clock
	input  wire logic                                 reset,     // Synchronous reset
	input  wire logic                                 in_valid,  // Sample strobe
	input  wire logic signed [SAMPLE_W-1:0]           sample,    // Input sample
	input  wire logic        [CODE_W-1:0]             code,      // Gain code
	output logic                                      out_valid, // Result strobe
	output logic signed [SAMPLE_W+CODE_W-SHIFT:0]     scaled     // Scaled sample
);

	logic signed [SAMPLE_W+CODE_W:0]       product;
	logic signed [SAMPLE_W+CODE_W-SHIFT:0] next_scaled;
	logic                                  next_out_valid;

	// Multiply, divide by two to the shift, force zero for a muted code
	always_comb begin
		product        = sample * $signed({1'b0, code});
		next_scaled    = product[SAMPLE_W+CODE_W:SHIFT];
		next_out_valid = in_valid;
		if (code == '0) begin
			next_scaled = '0; // Zero code mutes the path
		end
		if (!in_valid) begin
			next_scaled = scaled;
		end
	end

	// Result register
	always_ff @(posedge clk) begin
		if (reset) begin
			scaled    <= '0;
			out_valid <= 1'b0;
		end else begin
			scaled    <= next_scaled;
			out_valid <= next_out_valid;
		end
	end

	// Zero code gives zero output
	mute_zero_a: assert property (@(posedge clk) disable iff (reset)
		in_valid && code == '0 |=> scaled == '0)
		else $error("muted gain stage gave a nonzero result");

	// Unity code passes the sample unchanged
	unity_pass_a: assert property (@(posedge clk) disable iff (reset)
		in_valid && code == (CODE_W'(1) << SHIFT) |=> scaled == $past(sample))
		else $error("unity gain stage altered the sample");

endmodule

// ### hdl/ocm_regs.sv
// Overcurrent status, current limit select and call progress monitor gain registers
//
// Contract
// - Status bit shows detected loop overcurrent condition.
// - Trip at 160 mA, or 60 mA when selected.
// - Receive monitor gain resets to zero.
// - Receive monitor scaled by code over 64.
// - Zero receive code mutes receive contribution.
// - Transmit monitor scaled by code over 64.
// - Zero transmit code mutes transmit contribution.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module ocm_regs #(
	parameter int CUR_W = 10
) (
	input  wire logic                                 clk,                // System clock
	input  wire logic                                 reset,              // Synchronous reset
	input  wire ocm_pkg::ocm_req_t                    bus_req,            // Register request
	output logic [7:0]                                rd_data,            // Read data, next cycle
	input  wire logic [CUR_W-1:0]                     loop_current,       // Loop current, mA
	input  wire logic                                 loop_current_valid, // Current sample strobe
	input  wire ocm_pkg::ocm_audio_t                  mon_in,             // Receive and transmit
	output logic signed [ocm_pkg::SAMPLE_W-1:0]       call_progress_monitor_output, // Mix
	output logic                                      monitor_valid,      // Mix strobe
	output logic                                      overcurrent_status, // Overcurrent level
	output logic                                      current_limit_select, // Limit select
	output logic                                      irq                 // Interrupt, high
);

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	localparam int OUT_W = ocm_pkg::SAMPLE_W + 8 - ocm_pkg::GAIN_SHIFT + 1;

	logic [7:0]                          rx_gain;
	logic [7:0]                          tx_gain;
	logic [7:0]                          ctrl;
	logic [ocm_pkg::IRQ_W-1:0]           irq_status;
	logic [ocm_pkg::IRQ_W-1:0]           irq_mask;
	logic [7:0]                          next_rx_gain;
	logic [7:0]                          next_tx_gain;
	logic [7:0]                          next_ctrl;
	logic [ocm_pkg::IRQ_W-1:0]           next_irq_status;
	logic [ocm_pkg::IRQ_W-1:0]           next_irq_mask;
	logic [7:0]                          next_rd_data;
	logic                                next_oc;
	logic [CUR_W-1:0]                    oc_threshold;
	logic [ocm_pkg::IRQ_W-1:0]           events;
	logic                                wr_hit_rx;
	logic                                wr_hit_tx;
	logic                                wr_hit_ctrl;
	logic                                wr_hit_irq;
	logic                                wr_hit_mask;
	logic signed [OUT_W-1:0]             scaled_rx;
	logic signed [OUT_W-1:0]             scaled_tx;
	logic                                rx_done;
	logic                                tx_done;
	logic signed [ocm_pkg::MIX_W-1:0]    mix_sum;
	logic signed [ocm_pkg::SAMPLE_W-1:0] next_mon_out;
	logic                                next_mon_valid;
	logic                                mix_sat;

	// ---------------------------------------------------------------
	// Write decode
	// ---------------------------------------------------------------

	// Address match for each writable register
	assign wr_hit_rx   = bus_req.wr && bus_req.addr == ocm_pkg::ADDR_RX_GAIN;
	assign wr_hit_tx   = bus_req.wr && bus_req.addr == ocm_pkg::ADDR_TX_GAIN;
	assign wr_hit_ctrl = bus_req.wr && bus_req.addr == ocm_pkg::ADDR_CTRL;
	assign wr_hit_irq  = bus_req.wr && bus_req.addr == ocm_pkg::ADDR_IRQ_STATUS;
	assign wr_hit_mask = bus_req.wr && bus_req.addr == ocm_pkg::ADDR_IRQ_MASK;

	// ---------------------------------------------------------------
	// Overcurrent detector
	// ---------------------------------------------------------------

	// Threshold follows the limit select; status tracks each current sample
	always_comb begin
		if (ctrl[ocm_pkg::CTRL_CURRENT_LIMIT_SELECT_BIT]) begin
			oc_threshold = CUR_W'(ocm_pkg::OC_THR_ILIM1_MA);
		end else begin
			oc_threshold = CUR_W'(ocm_pkg::OC_THR_ILIM0_MA);
		end
		next_oc = overcurrent_status; // Bus writes never reach here
		if (loop_current_valid) begin
			next_oc = loop_current >= oc_threshold;
		end
	end

	assign current_limit_select = ctrl[ocm_pkg::CTRL_CURRENT_LIMIT_SELECT_BIT];

	// ---------------------------------------------------------------
	// Control registers
	// ---------------------------------------------------------------

	// Gain codes and mask take the write data on a matching write, control keeps only bit 0
	always_comb begin
		next_rx_gain  = rx_gain;
		next_tx_gain  = tx_gain;
		next_ctrl     = ctrl;
		next_irq_mask = irq_mask;
		if (wr_hit_rx) begin
			next_rx_gain = bus_req.wdata;
		end
		if (wr_hit_tx) begin
			next_tx_gain = bus_req.wdata;
		end
		if (wr_hit_ctrl) begin
			next_ctrl = bus_req.wdata & 8'h01;
		end
		if (wr_hit_mask) begin
			next_irq_mask = bus_req.wdata[ocm_pkg::IRQ_W-1:0];
		end
	end

	// ---------------------------------------------------------------
	// Interrupt status
	// ---------------------------------------------------------------

	// Sticky events; writing one clears, a new event in the same cycle wins
	always_comb begin
		events                          = '0;
		events[ocm_pkg::IRQ_OC_SET_BIT] = next_oc && !overcurrent_status;
		events[ocm_pkg::IRQ_OC_CLR_BIT] = !next_oc && overcurrent_status;
		events[ocm_pkg::IRQ_SAT_BIT]    = mix_sat;
		next_irq_status                 = irq_status;
		if (wr_hit_irq) begin
			next_irq_status = irq_status & ~bus_req.wdata[ocm_pkg::IRQ_W-1:0];
		end
		next_irq_status = next_irq_status | events;
	end

	assign irq = |(irq_status & irq_mask);

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------

	// Read data stand only in the cycle after the read strobe
	always_comb begin
		next_rd_data = 8'h00;
		if (bus_req.rd) begin
			case (bus_req.addr)
				ocm_pkg::ADDR_OC_STATUS: begin
					next_rd_data[ocm_pkg::OC_STATUS_BIT] = overcurrent_status;
				end
				ocm_pkg::ADDR_RX_GAIN: begin
					next_rd_data = rx_gain;
				end
				ocm_pkg::ADDR_TX_GAIN: begin
					next_rd_data = tx_gain;
				end
				ocm_pkg::ADDR_CTRL: begin
					next_rd_data = ctrl;
				end
				ocm_pkg::ADDR_IRQ_STATUS: begin
					next_rd_data[ocm_pkg::IRQ_W-1:0] = irq_status;
				end
				ocm_pkg::ADDR_IRQ_MASK: begin
					next_rd_data[ocm_pkg::IRQ_W-1:0] = irq_mask;
				end
				default: begin
					next_rd_data = 8'h00;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Monitor gain stages
	// ---------------------------------------------------------------

	// Receive path gain, muted at zero code
	ocm_gain_scale #(
		.SAMPLE_W (ocm_pkg::SAMPLE_W),
		.CODE_W   (8),
		.SHIFT    (ocm_pkg::GAIN_SHIFT)
	) u_rx_scale (
		.clk       (clk),
		.reset     (reset),
		.in_valid  (mon_in.valid),
		.sample    (mon_in.rx),
		.code      (rx_gain),
		.out_valid (rx_done),
		.scaled    (scaled_rx)
	);

	// Transmit path gain, muted at zero code
	ocm_gain_scale #(
		.SAMPLE_W (ocm_pkg::SAMPLE_W),
		.CODE_W   (8),
		.SHIFT    (ocm_pkg::GAIN_SHIFT)
	) u_tx_scale (
		.clk       (clk),
		.reset     (reset),
		.in_valid  (mon_in.valid),
		.sample    (mon_in.tx),
		.code      (tx_gain),
		.out_valid (tx_done),
		.scaled    (scaled_tx)
	);

	// ---------------------------------------------------------------
	// Monitor mixer
	// ---------------------------------------------------------------

	// Sum both scaled paths and clip to the output range
	always_comb begin
		mix_sum        = ocm_pkg::MIX_W'(scaled_rx) + ocm_pkg::MIX_W'(scaled_tx);
		mix_sat        = 1'b0;
		next_mon_valid = rx_done && tx_done;
		next_mon_out   = call_progress_monitor_output;
		if (next_mon_valid) begin
			if (mix_sum > ocm_pkg::MIX_MAX) begin
				next_mon_out = ocm_pkg::SAMPLE_W'(ocm_pkg::MIX_MAX);
				mix_sat      = 1'b1;
			end else if (mix_sum < ocm_pkg::MIX_MIN) begin
				next_mon_out = ocm_pkg::SAMPLE_W'(ocm_pkg::MIX_MIN);
				mix_sat      = 1'b1;
			end else begin
				next_mon_out = mix_sum[ocm_pkg::SAMPLE_W-1:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// State registers
	// ---------------------------------------------------------------

	// All registered state of the bank outside the two gain stages
	always_ff @(posedge clk) begin
		if (reset) begin
			rx_gain                      <= ocm_pkg::RX_GAIN_RST;
			tx_gain                      <= ocm_pkg::TX_GAIN_RST;
			ctrl                         <= ocm_pkg::CTRL_RST;
			irq_status                   <= '0;
			irq_mask                     <= ocm_pkg::IRQ_MASK_RST;
			overcurrent_status           <= 1'b0;
			rd_data                      <= 8'h00;
			call_progress_monitor_output <= '0;
			monitor_valid                <= 1'b0;
		end else begin
			rx_gain                      <= next_rx_gain;
			tx_gain                      <= next_tx_gain;
			ctrl                         <= next_ctrl;
			irq_status                   <= next_irq_status;
			irq_mask                     <= next_irq_mask;
			overcurrent_status           <= next_oc;
			rd_data                      <= next_rd_data;
			call_progress_monitor_output <= next_mon_out;
			monitor_valid                <= next_mon_valid;
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------

	// A sample with one path at unity and the other muted
	sequence s_rx_only;
		mon_in.valid && rx_gain == ocm_pkg::GAIN_UNITY && tx_gain == 8'h00;
	endsequence

	sequence s_tx_only;
		mon_in.valid && tx_gain == ocm_pkg::GAIN_UNITY && rx_gain == 8'h00;
	endsequence

	oc_set_a: assert property (@(posedge clk) disable iff (reset)
		loop_current_valid && loop_current >= oc_threshold
		|=> overcurrent_status ##1 (overcurrent_status || $past(loop_current_valid)))
		else $error("overcurrent not reported after overload sample");

	oc_clear_a: assert property (@(posedge clk) disable iff (reset)
		loop_current_valid && loop_current < oc_threshold |=> !overcurrent_status)
		else $error("overcurrent reported without overload");

	thr_select_a: assert property (@(posedge clk) disable iff (reset)
		loop_current_valid && loop_current == CUR_W'(ocm_pkg::OC_THR_ILIM1_MA)
		|=> overcurrent_status == $past(current_limit_select))
		else $error("60 mA sample tripped with wrong limit select");

	rx_reset_a: assert property (@(posedge clk)
		reset |=> rx_gain == 8'h00 && call_progress_monitor_output == '0)
		else $error("receive gain not zero after reset");

	rx_unity_a: assert property (@(posedge clk) disable iff (reset)
		s_rx_only |-> ##2 monitor_valid && call_progress_monitor_output == $past(mon_in.rx, 2))
		else $error("unity receive gain altered the monitor output");

	rx_mute_a: assert property (@(posedge clk) disable iff (reset)
		s_tx_only |-> ##2 call_progress_monitor_output == $past(mon_in.tx, 2))
		else $error("muted receive path leaked into the monitor output");

	tx_unity_a: assert property (@(posedge clk) disable iff (reset)
		s_tx_only ##1 1'b1
		|=> monitor_valid && call_progress_monitor_output == $past(mon_in.tx, 2))
		else $error("unity transmit gain altered the monitor output");

	tx_mute_a: assert property (@(posedge clk) disable iff (reset)
		mon_in.valid && tx_gain == 8'h00 && rx_gain == 8'h00
		|-> ##2 call_progress_monitor_output == '0)
		else $error("muted transmit path leaked into the monitor output");

	status_ro_a: assert property (@(posedge clk) disable iff (reset)
		bus_req.wr && bus_req.addr == ocm_pkg::ADDR_OC_STATUS && !loop_current_valid
		|=> $stable(overcurrent_status))
		else $error("bus write changed overcurrent status");

	irq_level_a: assert property (@(posedge clk) disable iff (reset)
		$rose(overcurrent_status)
		|-> irq_status[ocm_pkg::IRQ_OC_SET_BIT]
			&& (irq || !irq_mask[ocm_pkg::IRQ_OC_SET_BIT]))
		else $error("overcurrent rise did not raise its interrupt");

	set_wins_a: assert property (@(posedge clk) disable iff (reset)
		events[ocm_pkg::IRQ_SAT_BIT] |=> irq_status[ocm_pkg::IRQ_SAT_BIT])
		else $error("interrupt event lost");

endmodule

// ### tb/ocm_regs_tb.sv
// Self-checking testbench for the overcurrent status and monitor gain register bank
`timescale 1ns/1ps
module ocm_regs_tb;

	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic                                clk;
	logic                                reset;
	ocm_pkg::ocm_req_t                   bus_req;
	logic [7:0]                          rd_data;
	logic [9:0]                          loop_current;
	logic                                loop_current_valid;
	ocm_pkg::ocm_audio_t                 mon_in;
	logic signed [ocm_pkg::SAMPLE_W-1:0] mon_out;
	logic                                monitor_valid;
	logic                                overcurrent_status;
	logic                                current_limit_select;
	logic                                irq;
	int                                  err_count;
	int                                  n_checks;
	logic [7:0]                          codes [6];

	ocm_regs #(.CUR_W(10)) ocm_regs_inst (
		.clk                          (clk),
		.reset                        (reset),
		.bus_req                      (bus_req),
		.rd_data                      (rd_data),
		.loop_current                 (loop_current),
		.loop_current_valid           (loop_current_valid),
		.mon_in                       (mon_in),
		.call_progress_monitor_output (mon_out),
		.monitor_valid                (monitor_valid),
		.overcurrent_status           (overcurrent_status),
		.current_limit_select         (current_limit_select),
		.irq                          (irq)
	);

	// Free-running 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ---------------------------------------------------------------
	// Shared tasks, all entered just after a rising edge
	// ---------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR at %0t ns: got 0x%0h expected 0x%0h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
		@(posedge clk);
		bus_req <= '0;
		@(posedge clk);
	endtask

	// Read data is looked at only in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
		bus_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
		@(posedge clk);
		bus_req <= '0;
		#1 chk(rd_data, exp);
		@(posedge clk);
	endtask

	task automatic oc_sample(input logic [9:0] cur, input logic exp);
		loop_current       <= cur;
		loop_current_valid <= 1'b1;
		@(posedge clk);
		loop_current_valid <= 1'b0;
		#1 chk(overcurrent_status, exp);
		@(posedge clk);
	endtask

	// Expected mix: each path floored after the divide by 64, then saturated
	function automatic logic [15:0] exp_mix(input int rx, input int tx, input int rg, input int tg);
		int sum;
		sum = ((rx * rg) >>> 6) + ((tx * tg) >>> 6);
		if (sum > 32767) sum = 32767;
		if (sum < -32768) sum = -32768;
		return sum[15:0];
	endfunction

	// One sample in, result two edges later
	task automatic mon_sample(input int rx, input int tx, input int rg, input int tg);
		mon_in <= '{valid: 1'b1, rx: 16'(rx), tx: 16'(tx)};
		@(posedge clk);
		mon_in.valid <= 1'b0;
		@(posedge clk);
		#1 chk(monitor_valid, 1'b1);
		chk(mon_out, exp_mix(rx, tx, rg, tg));
		@(posedge clk);
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		rd_chk(ocm_pkg::ADDR_RX_GAIN, 8'h00);
		rd_chk(ocm_pkg::ADDR_TX_GAIN, 8'h00);
		chk(overcurrent_status, 1'b0);
		chk(irq, 1'b0);
		mon_sample(12000, -9000, 0, 0);
		$display("test reset values done");
	endtask

	task automatic t_overcurrent();
		oc_sample(10'h09F, 1'b0);
		oc_sample(10'h0A0, 1'b1);
		oc_sample(10'h3FF, 1'b1);
		oc_sample(10'h000, 1'b0);
		wr_reg(ocm_pkg::ADDR_CTRL, 8'h01);
		chk(current_limit_select, 1'b1);
		oc_sample(10'h03B, 1'b0);
		oc_sample(10'h03C, 1'b1);
		wr_reg(ocm_pkg::ADDR_CTRL, 8'h00);
		chk(current_limit_select, 1'b0);
		oc_sample(10'h03C, 1'b0);
		$display("test overcurrent thresholds done");
	endtask

	task automatic t_status_ro();
		wr_reg(ocm_pkg::ADDR_OC_STATUS, 8'hFF);
		rd_chk(ocm_pkg::ADDR_OC_STATUS, 8'h00);
		chk(overcurrent_status, 1'b0);
		oc_sample(10'h0C8, 1'b1);
		wr_reg(ocm_pkg::ADDR_OC_STATUS, 8'h00);
		rd_chk(ocm_pkg::ADDR_OC_STATUS, 8'h01);
		oc_sample(10'h000, 1'b0);
		$display("test read-only status done");
	endtask

	task automatic t_gains();
		codes = '{8'h40, 8'h20, 8'h10, 8'h7F, 8'hFF, 8'h01};
		foreach (codes[i]) begin
			wr_reg(ocm_pkg::ADDR_RX_GAIN, codes[i]);
			rd_chk(ocm_pkg::ADDR_RX_GAIN, codes[i]);
			mon_sample(1000, -77, codes[i], 0);
			mon_sample(-3, 500, codes[i], 0);
		end
		wr_reg(ocm_pkg::ADDR_RX_GAIN, 8'h00);
		mon_sample(32767, 0, 0, 0);
		foreach (codes[i]) begin
			wr_reg(ocm_pkg::ADDR_TX_GAIN, codes[i]);
			rd_chk(ocm_pkg::ADDR_TX_GAIN, codes[i]);
			mon_sample(900, -1000, 0, codes[i]);
		end
		wr_reg(ocm_pkg::ADDR_RX_GAIN, 8'h40);
		wr_reg(ocm_pkg::ADDR_TX_GAIN, 8'h20);
		mon_sample(300, -201, 64, 32);
		wr_reg(ocm_pkg::ADDR_TX_GAIN, 8'h00);
		mon_sample(300, -32768, 64, 0);
		$display("test monitor gains done");
	endtask

	task automatic t_irq();
		wr_reg(ocm_pkg::ADDR_IRQ_STATUS, 8'h07);
		rd_chk(ocm_pkg::ADDR_IRQ_STATUS, 8'h00);
		oc_sample(10'h0C8, 1'b1);
		rd_chk(ocm_pkg::ADDR_IRQ_STATUS, 8'h01);
		chk(irq, 1'b0);
		wr_reg(ocm_pkg::ADDR_IRQ_MASK, 8'h01);
		chk(irq, 1'b1);
		wr_reg(ocm_pkg::ADDR_IRQ_STATUS, 8'h01);
		chk(irq, 1'b0);
		wr_reg(ocm_pkg::ADDR_RX_GAIN, 8'hFF);
		wr_reg(ocm_pkg::ADDR_IRQ_MASK, 8'h04);
		mon_sample(32767, 0, 255, 0);
		chk(irq, 1'b1);
		rd_chk(ocm_pkg::ADDR_IRQ_STATUS, 8'h04);
		wr_reg(ocm_pkg::ADDR_IRQ_STATUS, 8'h04);
		chk(irq, 1'b0);
		mon_sample(-32768, 0, 255, 0);
		chk(irq, 1'b1);
		wr_reg(ocm_pkg::ADDR_IRQ_STATUS, 8'h04);
		chk(irq, 1'b0);
		oc_sample(10'h000, 1'b0);
		rd_chk(ocm_pkg::ADDR_IRQ_STATUS, 8'h02);
		// Overcurrent rise and its clear land in one cycle: the event wins
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: ocm_pkg::ADDR_IRQ_STATUS, wdata: 8'h01};
		loop_current <= 10'h0C8;
		loop_current_valid <= 1'b1;
		@(posedge clk);
		bus_req <= '0;
		loop_current_valid <= 1'b0;
		@(posedge clk);
		rd_chk(ocm_pkg::ADDR_IRQ_STATUS, 8'h03);
		oc_sample(10'h000, 1'b0);
		rd_chk(8'h20, 8'h00);
		$display("test interrupts done");
	endtask

	// ---------------------------------------------------------------
	// Verdict and run control
	// ---------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Watchdog far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		end_of_test();
	end

	// Main sequence
	initial begin
		err_count          = 0;
		n_checks           = 0;
		reset              = 1'b1;
		bus_req            = '0;
		loop_current       = 10'h000;
		loop_current_valid = 1'b0;
		mon_in             = '0;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_reset();
		t_overcurrent();
		t_status_ro();
		t_gains();
		t_irq();
		end_of_test();
	end

endmodule
